// *** dv/test_ufc_top.sv ***
// Testbench: register-driven tests of the serial port
`timescale 1ns/1ps
`default_nettype none
module test_ufc_top;
    logic        core_clk;
    logic        rst_n;
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
    logic [31:0] rdata;
    logic        rxd_in;
    logic        txd_out;
    logic        rx_ready_out_n;
    logic        tx_permit_in_n;
    logic        irq;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    ufc_top #(.RX_DEPTH(8)) DUT (
        .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .rxd_in(rxd_in), .txd_out(txd_out),
        .rx_ready_out_n(rx_ready_out_n), .tx_permit_in_n(tx_permit_in_n),
        .irq(irq));
    ufc_host_model #(.BIT_CYC(4)) host (.core_clk(core_clk), .txd(txd_out),
        .rdy_n(rx_ready_out_n), .rxd(rxd_in));
    always #50 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            results();
        end
    end
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : results
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Leaves one idle cycle so back-to-back writes never reuse a step
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        addr <= a;
        rd   <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
        v = rdata;
    endtask : rd_reg
    task automatic chk_reg(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] v;
        rd_reg(a, v);
        check(v, e);
    endtask : chk_reg
    task automatic chk_bit(input logic [7:0] a, input int b, input logic e);
        logic [31:0] v;
        rd_reg(a, v);
        check(32'(v[b]), 32'(e));
    endtask : chk_bit
    // Read follows the write with no gap
    task automatic wrrd(input logic [7:0] a, input logic [31:0] d,
                        input logic [31:0] e);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        chk_reg(a, e);
    endtask : wrrd
    task automatic wait_host(input int n);
        int k;
        k = 0;
        while (host.got.size() < n && k < 3000) begin
            @(posedge core_clk);
            k++;
        end
        check(32'(host.got.size()), 32'(n));
    endtask : wait_host
    initial begin
        core_clk       = 1'b0;
        rst_n          = 1'b0;
        addr           = 8'h00;
        wdata          = 32'h0;
        wr             = 1'b0;
        rd             = 1'b0;
        tx_permit_in_n = 1'b1;
        repeat (16) @(posedge core_clk);
        rst_n <= 1'b1;
        @(posedge core_clk);
        chk_reg(ufc_pkg::ADDR_CTRL, 32'h3);
        chk_reg(ufc_pkg::ADDR_OSR, 32'hc);
        chk_reg(ufc_pkg::ADDR_DIV, 32'h7);
        chk_reg(ufc_pkg::ADDR_TMO, 32'h20);
        chk_reg(ufc_pkg::ADDR_MASK, 32'h0);
        chk_reg(8'h30, 32'h0);
        check(32'(rx_ready_out_n), 32'h0);
        $display("reset test done");
        wrrd(ufc_pkg::ADDR_OSR, 32'h0, 32'h1);
        wrrd(ufc_pkg::ADDR_OSR, 32'hffff, 32'hffff);
        wrrd(ufc_pkg::ADDR_CTRL, 32'h7, 32'h7);
        wrrd(ufc_pkg::ADDR_CTRL, 32'h1, 32'h1);
        check(32'(rx_ready_out_n), 32'h1);
        wrrd(ufc_pkg::ADDR_CTRL, 32'h3, 32'h3);
        wrrd(ufc_pkg::ADDR_OSR, 32'h4, 32'h4);
        wrrd(ufc_pkg::ADDR_DIV, 32'h1, 32'h1);
        $display("config test done");
        tx_permit_in_n <= 1'b0;
        wr_reg(ufc_pkg::ADDR_TXD, 32'ha5);
        wait_host(1);
        wr_reg(ufc_pkg::ADDR_TXD, 32'h3c);
        wait_host(2);
        check(32'(host.got[0]), 32'ha5);
        check(32'(host.got[1]), 32'h3c);
        // Withdraw permit once the frame is under way
        wr_reg(ufc_pkg::ADDR_TXD, 32'h81);
        repeat (2) @(posedge core_clk);
        tx_permit_in_n <= 1'b1;
        wait_host(3);
        check(32'(host.got[2]), 32'h81);
        wr_reg(ufc_pkg::ADDR_TXD, 32'h7e);
        repeat (200) @(posedge core_clk);
        check(32'(host.got.size()), 32'h3);
        wrrd(ufc_pkg::ADDR_CTRL, 32'h2, 32'h2);
        tx_permit_in_n <= 1'b0;
        repeat (100) @(posedge core_clk);
        check(32'(host.got.size()), 32'h3);
        wrrd(ufc_pkg::ADDR_CTRL, 32'h3, 32'h3);
        wait_host(4);
        check(32'(host.got[3]), 32'h7e);
        check(32'(host.bad_stop), 32'h0);
        $display("transmit test done");
        host.send(8'h5a, 1'b1, 1'b0);
        repeat (4) @(posedge core_clk);
        chk_reg(ufc_pkg::ADDR_RXD, 32'h5a);
        for (int i = 0; i < 9; i++) begin
            host.send(8'h10 + 8'(i), 1'b1, i > 3);
            if (i == 3)
                check(32'(rx_ready_out_n), 32'h1);
            if (i == 7)
                chk_bit(ufc_pkg::ADDR_EVT, ufc_pkg::EV_OVERRUN, 1'b0);
        end
        chk_bit(ufc_pkg::ADDR_EVT, ufc_pkg::EV_OVERRUN, 1'b1);
        for (int i = 0; i < 8; i++) begin
            chk_reg(ufc_pkg::ADDR_RXD, 32'h10 + 32'(i));
        end
        check(32'(rx_ready_out_n), 32'h0);
        $display("flow test done");
        wr_reg(ufc_pkg::ADDR_EVT, 32'h1f);
        host.send(8'hc3, 1'b0, 1'b0);
        repeat (8) @(posedge core_clk);
        chk_bit(ufc_pkg::ADDR_EVT, ufc_pkg::EV_FRAMING, 1'b1);
        chk_bit(ufc_pkg::ADDR_STAT, ufc_pkg::ST_RX_AVAIL, 1'b0);
        $display("framing test done");
        wrrd(ufc_pkg::ADDR_TMO, 32'h5, 32'h5);
        host.send(8'h44, 1'b1, 1'b0);
        wr_reg(ufc_pkg::ADDR_EVT, 32'h1f);
        repeat (6) @(posedge core_clk);
        chk_bit(ufc_pkg::ADDR_EVT, ufc_pkg::EV_TIMEOUT, 1'b0);
        repeat (14) @(posedge core_clk);
        chk_bit(ufc_pkg::ADDR_EVT, ufc_pkg::EV_TIMEOUT, 1'b1);
        $display("timeout test done");
        check(32'(irq), 32'h0);
        wr_reg(ufc_pkg::ADDR_MASK, 32'h1);
        @(posedge core_clk);
        check(32'(irq), 32'h1);
        wr_reg(ufc_pkg::ADDR_EVT, 32'h1);
        @(posedge core_clk);
        check(32'(irq), 32'h0);
        wr_reg(ufc_pkg::ADDR_MASK, 32'h0);
        chk_reg(ufc_pkg::ADDR_RXD, 32'h44);
        $display("interrupt test done");
        results();
    end
endmodule : test_ufc_top
`default_nettype wire

// *** dv/ufc_checker.sv ***
// Checker: port-level properties of the serial port
`timescale 1ns/1ps
`default_nettype none
module ufc_checker #(
    parameter logic [15:0] RESET_OSR = ufc_pkg::RST_OSR,
    parameter logic [15:0] RESET_DIV = ufc_pkg::RST_DIV
) (
    input wire logic        core_clk,
    input wire logic        rst_n,
    input wire logic [7:0]  addr,
    input wire logic [31:0] wdata,
    input wire logic        wr,
    input wire logic        rd,
    input wire logic [31:0] rdata,
    input wire logic        rxd_in,
    input wire logic        txd_out,
    input wire logic        rx_ready_out_n,
    input wire logic        tx_permit_in_n,
    input wire logic        irq
);
    logic [15:0] osr_m;
    logic [15:0] div_m;
    logic [47:0] run;
    logic        idle;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Rate mirror lets the checker tell a long high bit run from idle
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            osr_m <= RESET_OSR;
            div_m <= RESET_DIV;
            run   <= '0;
        end else begin
            if (wr && addr == ufc_pkg::ADDR_OSR)
                osr_m <= (wdata[15:0] == 16'h0) ? 16'h1 : wdata[15:0];
            if (wr && addr == ufc_pkg::ADDR_DIV)
                div_m <= (wdata[15:0] == 16'h0) ? 16'h1 : wdata[15:0];
            run <= txd_out ? run + 48'h1 : 48'h0;
        end
    end
    // Nine high bit times plus margin cannot sit inside one frame
    assign idle = run > 48'h9 * 48'(osr_m) * 48'(div_m) + 48'h1;
    sequence blocked_s;
        tx_permit_in_n [*3] ##0 idle;
    endsequence
    property back_p(a, m);
        logic [31:0] v;
        (wr && addr == a && (wdata & m) != '0, v = wdata & m)
            ##1 (rd && addr == a) |=> (rdata & m) == v;
    endproperty
    osr_back_a: assert property (
        back_p(ufc_pkg::ADDR_OSR, 32'hffff))
        else $error("oversample count read back wrong");
    div_back_a: assert property (
        back_p(ufc_pkg::ADDR_DIV, 32'hffff))
        else $error("dividing ratio read back wrong");
    tmo_back_a: assert property (
        back_p(ufc_pkg::ADDR_TMO, 32'hffff))
        else $error("timeout threshold read back wrong");
    sel_back_a: assert property (back_p(ufc_pkg::ADDR_CTRL, 32'h7))
        else $error("control bits read back wrong");
    ready_rst_a: assert property (
        $rose(rst_n) |-> ##[0:2] !rx_ready_out_n)
        else $error("ready not asserted after reset");
    ready_off_a: assert property (
        wr && addr == ufc_pkg::ADDR_CTRL && !wdata[ufc_pkg::CTRL_RX_EN]
        |-> ##[1:3] rx_ready_out_n)
        else $error("ready kept low with receiver off");
    hold_idle_a: assert property (blocked_s |=> txd_out)
        else $error("frame started while permit high");
    tx_rst_a: assert property ($rose(rst_n) |-> txd_out [*2])
        else $error("serial output not idle high after reset");
    irq_off_a: assert property (
        wr && addr == ufc_pkg::ADDR_MASK && wdata[4:0] == 5'h00
        |-> ##2 !irq)
        else $error("interrupt high with all events masked");
endmodule : ufc_checker
bind ufc_top ufc_checker #(.RESET_OSR(RESET_OSR), .RESET_DIV(RESET_DIV)) chk (
    .core_clk(core_clk), .rst_n(rst_n), .addr(addr), .wdata(wdata),
    .wr(wr), .rd(rd), .rdata(rdata), .rxd_in(rxd_in), .txd_out(txd_out),
    .rx_ready_out_n(rx_ready_out_n), .tx_permit_in_n(tx_permit_in_n),
    .irq(irq));
`default_nettype wire

// *** dv/ufc_host_model.sv ***
// Far-end host model: frame sender and frame receiver
`timescale 1ns/1ps
`default_nettype none
module ufc_host_model #(
    parameter int BIT_CYC = 4
) (
    input  wire logic core_clk,
    input  wire logic txd,
    input  wire logic rdy_n,
    output var logic  rxd
);
    logic [7:0] got[$];
    int         bad_stop = 0;
    initial rxd = 1'b1;
    // Waits for ready unless a test pushes on regardless
    task automatic send(input logic [7:0] b, input bit stop, input bit push);
        logic [9:0] fr;
        int         n;
        fr = {stop, b, 1'b0};
        n = 0;
        while (rdy_n && !push && n < 4000) begin
            @(posedge core_clk);
            n++;
        end
        for (int i = 0; i < 10; i++) begin
            rxd <= fr[i];
            repeat (BIT_CYC) @(posedge core_clk);
        end
        rxd <= 1'b1;
        @(posedge core_clk);
    endtask : send
    // Every frame is taken, however late after ready was withdrawn
    initial forever begin : rx_side
        logic [7:0] b;
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge core_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYC) @(posedge core_clk);
            b[i] = txd;
        end
        repeat (BIT_CYC) @(posedge core_clk);
        if (txd !== 1'b1) bad_stop++;
        got.push_back(b);
    end
endmodule : ufc_host_model
`default_nettype wire

// *** src/ufc_baud.sv ***
// Oversample tick generator: one pulse every div source clocks
`timescale 1ns/1ps
`default_nettype none
module ufc_baud (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] div,
    output logic             os_tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } ufc_baud_st_t;

    ufc_baud_st_t st;
    ufc_baud_st_t next_st;

    always_comb begin
        next_st      = st;
        next_st.tick = 1'b0;
        // A ratio of zero behaves as one, so the port never stalls
        if (st.cnt + 16'h0001 >= div) begin
            next_st.cnt  = 16'h0000;
            next_st.tick = 1'b1;
        end else begin
            next_st.cnt = st.cnt + 16'h0001;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign os_tick = st.tick;
endmodule : ufc_baud
`default_nettype wire

// *** src/ufc_pkg.sv ***
// Package: register map, field positions and reset values of the serial port
package ufc_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL  = 8'h00;
    localparam logic [7:0] ADDR_OSR   = 8'h04;
    localparam logic [7:0] ADDR_DIV   = 8'h08;
    localparam logic [7:0] ADDR_TXD   = 8'h0c;
    localparam logic [7:0] ADDR_RXD   = 8'h10;
    localparam logic [7:0] ADDR_STAT  = 8'h14;
    localparam logic [7:0] ADDR_EVT   = 8'h18;
    localparam logic [7:0] ADDR_MASK  = 8'h1c;
    localparam logic [7:0] ADDR_TMO   = 8'h20;
    // Control fields
    localparam int CTRL_TX_EN  = 0;
    localparam int CTRL_RX_EN  = 1;
    localparam int CTRL_CLKSEL = 2;
    // Status fields
    localparam int ST_TX_FULL  = 0;
    localparam int ST_TX_BUSY  = 1;
    localparam int ST_RX_AVAIL = 2;
    localparam int ST_RTS_N    = 3;
    localparam int ST_CTS_N    = 4;
    // Event bits, same layout in event and mask registers
    localparam int EV_TIMEOUT  = 0;
    localparam int EV_OVERRUN  = 1;
    localparam int EV_FRAMING  = 2;
    localparam int EV_RX_CHAR  = 3;
    localparam int EV_TX_TAKEN = 4;
    localparam int EV_W        = 5;
    // Reset values
    localparam logic [2:0]  RST_CTRL  = 3'h3;
    localparam logic [15:0] RST_OSR   = 16'h000c;
    localparam logic [15:0] RST_DIV   = 16'h0007;
    localparam logic [15:0] RST_TMO   = 16'h0020;
    localparam logic [4:0]  RST_MASK  = 5'h00;
    // Frame shape: start, eight data bits, stop
    localparam int FRAME_BITS = 10;
    // Frames the far end may still send after ready is withdrawn
    localparam int FLOW_SLACK = 4;
    // Source clock choices, for software rate arithmetic
    localparam int SRC_HZ_LO = 39_000_000;
    localparam int SRC_HZ_HI = 52_000_000;
endpackage : ufc_pkg

// *** src/ufc_top.sv ***
// Serial port with hardware flow control, baud generator and error flags
//
// Functional notes
// - Four wires: rx, tx, ready out, permit in
// - Bit rate programmable, 2400 bps upward
// - Reset bit rate set by build parameters
// - Transmit while permit low and data pending
// - Permit high stops only between frames
// - Ready low when receive buffer has room
// - Up to four extra frames after ready withdrawn
// - Source clock select: two frequencies; the select bit is only stored and read back, it switches nothing
// - Oversample count programmable 1 to 65535
// - Rate equals source over oversample times ratio
// - Fastest rate: 52 MHz, one, one
// - Three receive errors: timeout, overrun, framing
// - Gap at or over threshold flags timeout
// - Character arriving on full buffer flags overrun
// - Bad stop bit flags framing error
// - Commands and data share the same lines
`timescale 1ns/1ps
`default_nettype none
module ufc_top #(
    parameter int          RX_DEPTH  = 8,
    parameter logic [15:0] RESET_OSR = ufc_pkg::RST_OSR,
    parameter logic [15:0] RESET_DIV = ufc_pkg::RST_DIV
) (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  addr,
    input  wire logic [31:0] wdata,
    input  wire logic        wr,
    input  wire logic        rd,
    output logic [31:0]      rdata,
    input  wire logic        rxd_in,
    output logic             txd_out,
    output logic             rx_ready_out_n,
    input  wire logic        tx_permit_in_n,
    output logic             irq
);
    localparam int PW = $clog2(RX_DEPTH);
    localparam int CW = $clog2(RX_DEPTH + 1);
    // Room needed before inviting more data, so late frames still fit
    localparam int READY_ROOM = ufc_pkg::FLOW_SLACK + 1;

    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP}
        ufc_rx_state_t;

    typedef struct packed {
        logic [2:0]                ctrl;
        logic [15:0]               osr;
        logic [15:0]               div;
        logic [15:0]               tmo;
        logic [4:0]                mask;
        logic [4:0]                evt;
        logic [RX_DEPTH-1:0][7:0]  mem;
        logic [PW-1:0]             wp;
        logic [PW-1:0]             rp;
        logic [CW-1:0]             fill;
        ufc_rx_state_t             rx_state;
        logic [15:0]               rx_cnt;
        logic [2:0]                rx_bitn;
        logic [7:0]                rx_sh;
        logic [15:0]               gap_os;
        logic [15:0]               gap_bits;
        logic                      gap_arm;
        logic [7:0]                tx_hold;
        logic                      tx_full;
        logic [31:0]               rdata;
        logic                      irq;
        logic                      rts_n;
    } ufc_top_st_t;

    ufc_top_st_t st;
    ufc_top_st_t next_st;

    logic os_tick;
    logic tx_take;
    logic tx_busy;

    // A ratio of one ticks every cycle, the fastest rate
    ufc_baud u_baud (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .div      (st.div),
        .os_tick  (os_tick)
    );

    // Transmit side shares the oversample tick with the receiver
    ufc_tx u_tx (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .os_tick  (os_tick),
        .osr      (st.osr),
        .enable   (st.ctrl[ufc_pkg::CTRL_TX_EN]),
        .permit_n (tx_permit_in_n),
        .valid    (st.tx_full),
        .data     (st.tx_hold),
        .take     (tx_take),
        .busy     (tx_busy),
        .txd      (txd_out)
    );

    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        logic [PW-1:0] r;
        r = (32'(p) == RX_DEPTH - 1) ? '0 : p + PW'(1);
        return r;
    endfunction : ptr_inc

    always_comb begin
        logic [4:0]  ev;
        logic        push;
        logic        pop;
        logic        half;
        logic        bit_end;
        ev      = 5'h00;
        push    = 1'b0;
        pop     = 1'b0;
        half    = (st.rx_cnt == {1'b0, st.osr[15:1]});
        bit_end = (st.rx_cnt + 16'h0001 >= st.osr);
        next_st = st;

        // Register writes
        if (wr) begin
            unique case (addr)
                ufc_pkg::ADDR_CTRL: next_st.ctrl = wdata[2:0];
                // Zero would stall; it is kept as one
                ufc_pkg::ADDR_OSR:
                    next_st.osr = (wdata[15:0] == 16'h0000) ? 16'h0001
                                                            : wdata[15:0];
                ufc_pkg::ADDR_DIV:  next_st.div  = wdata[15:0];
                ufc_pkg::ADDR_TMO:  next_st.tmo  = wdata[15:0];
                ufc_pkg::ADDR_MASK: next_st.mask = wdata[4:0];
                ufc_pkg::ADDR_TXD: begin
                    // A write while the holding byte is still full is dropped
                    if (!st.tx_full) begin
                        next_st.tx_hold = wdata[7:0];
                        next_st.tx_full = 1'b1;
                    end
                end
                default: ;
            endcase
        end
        if (tx_take) begin
            next_st.tx_full = 1'b0;
            ev[ufc_pkg::EV_TX_TAKEN] = 1'b1;
        end

        // Register reads, data stands one cycle after the strobe
        next_st.rdata = 32'h0000_0000;
        if (rd) begin
            unique case (addr)
                ufc_pkg::ADDR_CTRL: next_st.rdata = {29'h0, st.ctrl};
                ufc_pkg::ADDR_OSR:  next_st.rdata = {16'h0, st.osr};
                ufc_pkg::ADDR_DIV:  next_st.rdata = {16'h0, st.div};
                ufc_pkg::ADDR_TMO:  next_st.rdata = {16'h0, st.tmo};
                ufc_pkg::ADDR_MASK: next_st.rdata = {27'h0, st.mask};
                ufc_pkg::ADDR_EVT:  next_st.rdata = {27'h0, st.evt};
                ufc_pkg::ADDR_TXD:  next_st.rdata = {24'h0, st.tx_hold};
                ufc_pkg::ADDR_STAT: next_st.rdata = {27'h0,
                                                     tx_permit_in_n,
                                                     st.rts_n,
                                                     st.fill != '0,
                                                     tx_busy,
                                                     st.tx_full};
                ufc_pkg::ADDR_RXD: begin
                    // Reading the data register pops the oldest byte
                    if (st.fill != '0) begin
                        next_st.rdata = {24'h0, st.mem[st.rp]};
                        pop = 1'b1;
                    end
                end
                default: next_st.rdata = 32'h0000_0000;
            endcase
        end

        // Receiver: sample each bit in its middle oversample
        if (!st.ctrl[ufc_pkg::CTRL_RX_EN]) begin
            next_st.rx_state = RX_IDLE;
        end else if (os_tick) begin
            next_st.rx_cnt = bit_end ? 16'h0000 : st.rx_cnt + 16'h0001;
            unique case (st.rx_state)
                RX_IDLE: begin
                    next_st.rx_cnt = 16'h0000;
                    if (!rxd_in) begin
                        next_st.rx_state = RX_START;
                        next_st.rx_cnt   = 16'h0001;
                        if (st.osr == 16'h0001) begin
                            next_st.rx_cnt   = 16'h0000;
                            next_st.rx_state = RX_DATA;
                        end
                        next_st.rx_bitn = 3'h0;
                    end
                end
                RX_START: begin
                    // A glitch shorter than half a bit is not a start
                    if (half && rxd_in) begin
                        next_st.rx_state = RX_IDLE;
                    end else if (bit_end) begin
                        next_st.rx_state = RX_DATA;
                    end
                end
                RX_DATA: begin
                    if (half) begin
                        next_st.rx_sh = {rxd_in, st.rx_sh[7:1]};
                    end
                    if (bit_end) begin
                        next_st.rx_bitn = st.rx_bitn + 3'h1;
                        if (st.rx_bitn == 3'h7) begin
                            next_st.rx_state = RX_STOP;
                        end
                    end
                end
                RX_STOP: begin
                    // Leave at mid stop bit to catch the next start edge
                    if (half) begin
                        next_st.rx_state = RX_IDLE;
                        if (!rxd_in) begin
                            ev[ufc_pkg::EV_FRAMING] = 1'b1;
                        end else if (st.fill == CW'(RX_DEPTH) && !pop) begin
                            ev[ufc_pkg::EV_OVERRUN] = 1'b1;
                        end else begin
                            push = 1'b1;
                            ev[ufc_pkg::EV_RX_CHAR] = 1'b1;
                        end
                    end
                end
            endcase
        end

        // Receive buffer bookkeeping
        if (push) begin
            next_st.mem[st.wp] = st.rx_sh;
            next_st.wp = ptr_inc(st.wp);
        end
        if (pop) begin
            next_st.rp = ptr_inc(st.rp);
        end
        if (push && !pop) begin
            next_st.fill = st.fill + CW'(1);
        end else if (pop && !push) begin
            next_st.fill = st.fill - CW'(1);
        end

        // Ready is withdrawn early enough for late frames
        next_st.rts_n = !st.ctrl[ufc_pkg::CTRL_RX_EN] ||
                        (32'(next_st.fill) + READY_ROOM > RX_DEPTH);

        // Gap timer in bit times since the last character
        if (push || ev[ufc_pkg::EV_FRAMING] || ev[ufc_pkg::EV_OVERRUN]) begin
            next_st.gap_arm  = 1'b1;
            next_st.gap_os   = 16'h0000;
            next_st.gap_bits = 16'h0000;
        end else if (st.rx_state != RX_IDLE) begin
            next_st.gap_os   = 16'h0000;
            next_st.gap_bits = 16'h0000;
        end else if (st.gap_arm && os_tick) begin
            if (st.gap_os + 16'h0001 >= st.osr) begin
                next_st.gap_os   = 16'h0000;
                next_st.gap_bits = st.gap_bits + 16'h0001;
            end else begin
                next_st.gap_os = st.gap_os + 16'h0001;
            end
        end
        // Flag once per gap; a zero threshold turns the check off
        if (st.gap_arm && st.tmo != 16'h0000 && st.gap_bits >= st.tmo
            && st.rx_state == RX_IDLE) begin
            ev[ufc_pkg::EV_TIMEOUT] = 1'b1;
            next_st.gap_arm = 1'b0;
        end

        // Sticky events: write one clears, a new event wins
        if (wr && addr == ufc_pkg::ADDR_EVT) begin
            next_st.evt = st.evt & ~wdata[4:0];
        end
        next_st.evt = next_st.evt | ev;
        next_st.irq = |(next_st.evt & next_st.mask);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st          <= '0;
            st.ctrl     <= ufc_pkg::RST_CTRL;
            st.osr      <= RESET_OSR;
            st.div      <= RESET_DIV;
            st.tmo      <= ufc_pkg::RST_TMO;
            st.mask     <= ufc_pkg::RST_MASK;
            st.rx_state <= RX_IDLE;
            st.rts_n    <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign rdata          = st.rdata;
    assign rx_ready_out_n = st.rts_n;
    assign irq            = st.irq;
endmodule : ufc_top
`default_nettype wire

// *** src/ufc_tx.sv ***
// Transmit framer with frame-boundary flow control
`timescale 1ns/1ps
`default_nettype none
module ufc_tx (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        os_tick,
    input  wire logic [15:0] osr,
    input  wire logic        enable,
    input  wire logic        permit_n,
    input  wire logic        valid,
    input  wire logic [7:0]  data,
    output logic             take,
    output logic             busy,
    output logic             txd
);
    typedef enum logic {TX_IDLE, TX_SEND} ufc_tx_state_t;
    typedef struct packed {
        ufc_tx_state_t state;
        logic [9:0]    frame;
        logic [3:0]    bitn;
        logic [15:0]   cnt;
        logic          take;
        logic          txd;
    } ufc_tx_st_t;

    ufc_tx_st_t st;
    ufc_tx_st_t next_st;

    always_comb begin
        next_st      = st;
        next_st.take = 1'b0;
        unique case (st.state)
            TX_IDLE: begin
                next_st.txd = 1'b1;
                // Permit is looked at only here, between frames
                if (enable && valid && !permit_n) begin
                    next_st.frame = {1'b1, data, 1'b0};
                    next_st.bitn  = 4'h0;
                    next_st.cnt   = 16'h0000;
                    next_st.take  = 1'b1;
                    next_st.txd   = 1'b0;
                    next_st.state = TX_SEND;
                end
            end
            TX_SEND: begin
                if (os_tick) begin
                    if (st.cnt + 16'h0001 >= osr) begin
                        next_st.cnt = 16'h0000;
                        if (st.bitn == 4'(ufc_pkg::FRAME_BITS - 1)) begin
                            next_st.state = TX_IDLE;
                            next_st.txd   = 1'b1;
                        end else begin
                            next_st.bitn = st.bitn + 4'h1;
                            // LSB first after the start bit
                            next_st.txd  = st.frame[st.bitn + 4'h1];
                        end
                    end else begin
                        next_st.cnt = st.cnt + 16'h0001;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st       <= '0;
            st.state <= TX_IDLE;
            st.txd   <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign take = st.take;
    assign busy = (st.state == TX_SEND);
    assign txd  = st.txd;
endmodule : ufc_tx
`default_nettype wire
